// ==== rtl/status_resp_pkg.sv ====
// Shared types and constants for the serial status response block.
package status_resp_pkg;

   // Width of one serial frame and of the status word.
   localparam int unsigned FRAME_BITS     = 16;
   localparam int unsigned BYTE_BITS      = 8;
   localparam logic [4:0]  FRAME_BITS_CNT = 5'h10;
   localparam logic [4:0]  CMD_TYPE_SEEN  = 5'h02;
   localparam logic [4:0]  SECOND_BYTE_AT = 5'h08;

   // Command type field sits in the two top bits of the incoming frame.
   localparam int unsigned CMD_TYPE_HI = 15;
   localparam int unsigned CMD_TYPE_LO = 14;
   localparam logic [1:0]  CMD_READ_A  = 2'h0;
   localparam logic [1:0]  CMD_WRITE   = 2'h1;
   localparam logic [1:0]  CMD_READ_B  = 2'h3;

   // Bit positions of the status word.
   localparam int unsigned BIT_INT_PEND   = 15;
   localparam int unsigned BIT_WAKE_PEND  = 14;
   localparam int unsigned BIT_RST_PEND   = 13;
   localparam int unsigned BIT_CAN_GRP    = 12;
   localparam int unsigned BIT_LIN_GRP    = 11;
   localparam int unsigned BIT_IO_GRP     = 10;
   localparam int unsigned BIT_SAFE_GRP   = 9;
   localparam int unsigned BIT_REG_GRP    = 8;
   localparam int unsigned BIT_CAN_BUS    = 7;
   localparam int unsigned BIT_CAN_LOCAL  = 6;
   localparam int unsigned BIT_LIN_SECOND = 5;
   localparam int unsigned BIT_LIN_FIRST  = 4;
   localparam int unsigned BIT_IO_LOW     = 3;
   localparam int unsigned BIT_IO_HIGH    = 2;
   localparam int unsigned BIT_REG_HIGH   = 1;
   localparam int unsigned BIT_REG_LOW    = 0;

   // Reset values.
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   localparam logic [15:0] CMD_RESET     = 16'h0000;
   localparam logic [4:0]  CNT_RESET     = 5'h00;

   // Host must hold chip select low this long before the first clock edge.
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned CS_SETUP_NS     = 300;
   localparam int unsigned CS_SETUP_CYCLES =
      (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Pending events and their sources, all levels from the flag logic.
   typedef struct packed {
      logic int_pending;
      logic wake_pending;
      logic reset_pending;
      logic safe_source;
      logic monitor_source;
      logic can_bus_source;
      logic local_side_fault_source;
      logic second_lin_source;
      logic first_lin_source;
      logic io_low_subaddr_source;
      logic io_high_subaddr_source;
      logic regulator_high_subaddr_source;
      logic regulator_low_subaddr_source;
   } pending_flags_t;

   // Received command handed to the decoder.
   typedef struct packed {
      logic        valid;
      logic        is_write;
      logic        length_error;
      logic [15:0] word;
   } command_t;

   typedef enum logic [1:0] {
      CMD_KIND_READ,
      CMD_KIND_WRITE,
      CMD_KIND_UNKNOWN
   } cmd_kind_t;

endpackage : status_resp_pkg

// ==== rtl/bit_sync.sv ====
// Two-stage synchroniser for a bundle of independent levels.
`timescale 1ns/1ps
`default_nettype none
module bit_sync
   import status_resp_pkg::*;
#(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_t;

   sync_state_t state_reg;
   sync_state_t state_next;

   // The first stage feeds only the second stage.
   always_comb begin
      state_next        = state_reg;
      state_next.first  = async_i;
      state_next.second = state_reg.first;
      if (rst_i) begin
         state_next.first  = RESET_VAL;
         state_next.second = RESET_VAL;
      end
   end

   always_ff @(posedge clk_i) begin
      state_reg <= state_next;
   end

   assign sync_o = state_reg.second;

endmodule // bit_sync
`default_nettype wire

// ==== rtl/status_word_builder.sv ====
// Assembles the 16-bit status word from pending events and their sources.
`timescale 1ns/1ps
`default_nettype none
module status_word_builder
   import status_resp_pkg::*;
(
   input  wire pending_flags_t flags_i,
   output logic [15:0]         word_o
);

   always_comb begin
      word_o                 = STATUS_RESET;
      word_o[BIT_INT_PEND]   = flags_i.int_pending;
      word_o[BIT_WAKE_PEND]  = flags_i.wake_pending;
      word_o[BIT_RST_PEND]   = flags_i.reset_pending;
      word_o[BIT_CAN_GRP]    = flags_i.can_bus_source
                             | flags_i.local_side_fault_source;
      word_o[BIT_LIN_GRP]    = flags_i.second_lin_source
                             | flags_i.first_lin_source;
      word_o[BIT_IO_GRP]     = flags_i.io_low_subaddr_source
                             | flags_i.io_high_subaddr_source;
      word_o[BIT_SAFE_GRP]   = flags_i.safe_source;
      word_o[BIT_REG_GRP]    = flags_i.regulator_high_subaddr_source
                             | flags_i.regulator_low_subaddr_source
                             | flags_i.monitor_source;
      word_o[BIT_CAN_BUS]    = flags_i.can_bus_source;
      word_o[BIT_CAN_LOCAL]  = flags_i.local_side_fault_source;
      word_o[BIT_LIN_SECOND] = flags_i.second_lin_source;
      word_o[BIT_LIN_FIRST]  = flags_i.first_lin_source;
      word_o[BIT_IO_LOW]     = flags_i.io_low_subaddr_source;
      word_o[BIT_IO_HIGH]    = flags_i.io_high_subaddr_source;
      word_o[BIT_REG_HIGH]   = flags_i.regulator_high_subaddr_source;
      word_o[BIT_REG_LOW]    = flags_i.regulator_low_subaddr_source;
   end

endmodule // status_word_builder
`default_nettype wire

// ==== rtl/spi_status_response.sv ====
// Serial status responder: shifts the status word out while a command shifts in.
//
// Notes on behaviour
// - Read command types return only the fixed status byte, the rest reads zero.
// - Write command type returns fixed status byte then extended status byte.
// - Bit 15 shows an interrupt whose flags are still unread.
// - Bit 14 shows a wake-up whose flags are still unread.
// - Bit 13 shows a reset whose source flags are still unread.
// - Bit 12 shows the pending source is the CAN interface, bus or local.
// - Bit 11 shows the pending source is either LIN interface.
// - Bit 10 shows the pending source is the I/O interfaces.
// - Bit 9 shows the pending source is a safe-state condition.
// - Bit 8 shows a regulator or voltage monitoring source.
// - Bit 7 shows the CAN bus side as source.
// - Bit 6 shows a local CAN failure as source.
// - Bit 5 shows the second LIN interface as source.
// - Bit 4 shows the first LIN interface as source.
// - Bit 3 shows an I/O flag in the low sub-address register.
// - Bit 2 shows an I/O flag in the high sub-address register.
// - Bit 1 shows a regulator flag in the high sub-address register.
// - Bit 0 shows a regulator flag in the low sub-address register.
`timescale 1ns/1ps
`default_nettype none
module spi_status_response
   import status_resp_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire pending_flags_t flags_i,
   input  wire logic           sclk_i,
   input  wire logic           cs_n_i,
   input  wire logic           mosi_i,
   output logic                miso_o,
   output logic                miso_oe_o,
   output logic [15:0]         status_word_o,
   output logic                pending_any_o,
   output command_t            command_o,
   output cmd_kind_t           command_kind_o
);

   // System clock domain.

   typedef struct packed {
      logic [15:0] snapshot;
      logic        cs_prev;
      logic [1:0]  setup_cnt;
      command_t    command;
      cmd_kind_t   kind;
   } core_state_t;

   core_state_t core_reg;
   core_state_t core_next;

   logic [15:0] live_word;
   logic        cs_sync;
   logic [15:0] frame_word_sync_src;

   // Pure combinational view of the flags; reading it never clears them.
   status_word_builder u_builder (
      .flags_i (flags_i),
      .word_o  (live_word)
   );

   // Chip select crosses into the system domain as a level.
   bit_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b1)
   ) u_cs_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (cs_n_i),
      .sync_o  (cs_sync)
   );

   // Link clock domain; its control state is reset by chip select going high, its data state is not.

   typedef struct packed {
      logic [4:0] bit_cnt;
      logic       is_write;
   } link_ctrl_t;

   typedef struct packed {
      logic [15:0] rx_word;
      logic [4:0]  rx_cnt;
   } link_data_t;

   link_ctrl_t link_ctrl_reg;
   link_ctrl_t link_ctrl_next;
   link_data_t link_data_reg;
   link_data_t link_data_next;

   logic [15:0] rx_shifted;
   logic [1:0]  cmd_bits;
   logic        tx_bit;
   logic [3:0]  tx_index;

   assign rx_shifted = {link_data_reg.rx_word[14:0], mosi_i};
   // At the second rise the two type bits sit at the bottom of the shifter,
   // not yet at their final place in the frame.
   assign cmd_bits   = rx_shifted[CMD_TYPE_HI-CMD_TYPE_LO:0];

   always_comb begin
      link_ctrl_next = link_ctrl_reg;
      if (link_ctrl_reg.bit_cnt != FRAME_BITS_CNT) begin
         link_ctrl_next.bit_cnt = link_ctrl_reg.bit_cnt + 5'h01;
      end
      // The type is known once the second command bit is in.
      if (link_ctrl_reg.bit_cnt == (CMD_TYPE_SEEN - 5'h01)) begin
         link_ctrl_next.is_write = (cmd_bits == CMD_WRITE);
      end
   end

   // Counter and command type restart with every frame; no edge is
   // needed outside a frame because chip select clears them directly.
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         link_ctrl_reg <= '{bit_cnt: CNT_RESET, is_write: 1'b0};
      end else begin
         link_ctrl_reg <= link_ctrl_next;
      end
   end

   always_comb begin
      link_data_next         = link_data_reg;
      link_data_next.rx_word = rx_shifted;
      link_data_next.rx_cnt  = link_ctrl_next.bit_cnt;
   end

   // Data only: it is read in the system domain after chip select has
   // been high for two system cycles, when the link clock is idle.
   always_ff @(posedge sclk_i) begin
      link_data_reg <= link_data_next;
   end

   assign frame_word_sync_src = link_data_reg.rx_word;

   // MSB first, each bit placed after the rising edge that took the
   // previous command bit, so it is stable at the next rising edge.
   assign tx_index = 4'hf - link_ctrl_reg.bit_cnt[3:0];

   always_comb begin
      tx_bit = 1'b0;
      if (link_ctrl_reg.bit_cnt < SECOND_BYTE_AT) begin
         tx_bit = core_reg.snapshot[tx_index];
      end else if (link_ctrl_reg.bit_cnt < FRAME_BITS_CNT) begin
         if (link_ctrl_reg.is_write) begin
            tx_bit = core_reg.snapshot[tx_index];
         end else begin
            tx_bit = 1'b0;
         end
      end
   end

   assign miso_o    = tx_bit & ~cs_n_i;
   assign miso_oe_o = ~cs_n_i;

   // System domain state.

   always_comb begin
      core_next               = core_reg;
      core_next.cs_prev       = cs_sync;
      core_next.command.valid = 1'b0;

      // The snapshot only moves while synchronised chip select is high, up to two cycles
      // into a frame, so with the host setup time the link side shifts out one coherent word.
      if (cs_sync && core_reg.cs_prev) begin
         if (core_reg.setup_cnt != 2'h0) begin
            core_next.setup_cnt = core_reg.setup_cnt - 2'h1;
         end
         core_next.snapshot = live_word;
      end else begin
         core_next.setup_cnt = 2'(CS_SETUP_CYCLES - 1);
      end

      // Frame end: chip select seen rising after a frame.
      if (cs_sync && !core_reg.cs_prev) begin
         core_next.command.valid        = 1'b1;
         core_next.command.word         = frame_word_sync_src;
         core_next.command.length_error = (link_data_reg.rx_cnt != FRAME_BITS_CNT);
         core_next.command.is_write     =
            (frame_word_sync_src[CMD_TYPE_HI:CMD_TYPE_LO] == CMD_WRITE);
         case (frame_word_sync_src[CMD_TYPE_HI:CMD_TYPE_LO])
            CMD_READ_A: begin
               core_next.kind = CMD_KIND_READ;
            end
            CMD_READ_B: begin
               core_next.kind = CMD_KIND_READ;
            end
            CMD_WRITE: begin
               core_next.kind = CMD_KIND_WRITE;
            end
            default: begin
               core_next.kind = CMD_KIND_UNKNOWN;
            end
         endcase
      end

      if (rst_i) begin
         core_next.snapshot  = STATUS_RESET;
         core_next.cs_prev   = 1'b1;
         core_next.setup_cnt = 2'(CS_SETUP_CYCLES - 1);
         core_next.command   = '{valid: 1'b0, is_write: 1'b0,
                                 length_error: 1'b0, word: CMD_RESET};
         core_next.kind      = CMD_KIND_READ;
      end
   end

   always_ff @(posedge clk_i) begin
      core_reg <= core_next;
   end

   assign status_word_o  = core_reg.snapshot;
   assign pending_any_o  = core_reg.snapshot[BIT_INT_PEND]
                         | core_reg.snapshot[BIT_WAKE_PEND]
                         | core_reg.snapshot[BIT_RST_PEND];
   assign command_o      = core_reg.command;
   assign command_kind_o = core_reg.kind;

endmodule // spi_status_response
`default_nettype wire

// ==== tb/spi_status_response_chk.sv ====
// Concurrent checks for the serial status responder, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module spi_status_response_chk
   import status_resp_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire pending_flags_t flags_i,
   input  wire logic           cs_n_i,
   input  wire logic           miso_o,
   input  wire logic           miso_oe_o,
   input  wire logic [15:0]    status_word_o,
   input  wire logic           pending_any_o
);
   logic [2:0]  age_reg;
   logic [12:0] f;
   logic [15:0] exp_w;

   // The snapshot path waits on a synchroniser, so the checks built on s_idle hold off a few cycles after reset.
   always_ff @(posedge clk_i) begin
      age_reg <= rst_i ? 3'h0 : age_reg + 3'(age_reg != 3'h7);
   end

   assign f     = flags_i;
   assign exp_w = {f[12:10], |f[7:6], |f[5:4], |f[3:2], f[9], f[8] | (|f[1:0]), f[7:0]};

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_idle;
      cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2) && $past(cs_n_i, 3) && age_reg > 3'h4;
   endsequence
   sequence s_busy;
      !cs_n_i && !$past(cs_n_i) && !$past(cs_n_i, 2) && !$past(cs_n_i, 3);
   endsequence

   AST_INT_BIT: assert property (s_idle |=> status_word_o[15] == $past(exp_w[15]))
      else $error("interrupt pending bit wrong");
   AST_WAKE_BIT: assert property (s_idle |=> status_word_o[14] == $past(exp_w[14]))
      else $error("wake pending bit wrong");
   AST_RST_BIT: assert property (s_idle |=> status_word_o[13] == $past(exp_w[13]))
      else $error("reset pending bit wrong");
   AST_GROUP_BITS: assert property (s_idle |=> status_word_o[12:8] == $past(exp_w[12:8]))
      else $error("source group bits wrong");
   AST_DETAIL_BITS: assert property (s_idle |=> status_word_o[7:0] == $past(exp_w[7:0]))
      else $error("detailed source bits wrong");
   AST_FROZEN: assert property (s_busy |=> $stable(status_word_o))
      else $error("status word moved during a frame");
   AST_MISO_IDLE: assert property (cs_n_i && $past(cs_n_i) |-> !miso_oe_o && !miso_o)
      else $error("data out driven outside a frame");
   AST_OE_FRAME: assert property (!cs_n_i && !$past(cs_n_i) |-> miso_oe_o)
      else $error("data out not driven in a frame");
   AST_PEND_ANY: assert property (s_idle |=> pending_any_o == $past(|exp_w[15:13]))
      else $error("pending summary wrong");
endmodule // spi_status_response_chk

bind spi_status_response spi_status_response_chk chk (
   .clk_i(clk_i), .rst_i(rst_i), .flags_i(flags_i), .cs_n_i(cs_n_i), .miso_o(miso_o),
   .miso_oe_o(miso_oe_o), .status_word_o(status_word_o), .pending_any_o(pending_any_o));
`default_nettype wire

// ==== tb/spi_host_model.sv ====
// Host model: serial master that runs one frame per call.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b0;
      mosi_o = 1'b0;
      // A clean rising chip select clears the link bit counter and command type before the first frame.
      #1;
      cs_n_o = 1'b1;
   end

   // The serial clock only runs inside a frame; reply bits are taken just before each rise.
   task automatic frame(input logic [15:0] cmd, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      cs_n_o = 1'b0;
      #400;
      for (int i = 0; i < nbits; i++) begin
         mosi_o = cmd[15-i];
         #6;
         rx[15-i] = miso_i;
         sclk_o = 1'b1;
         #6;
         sclk_o = 1'b0;
      end
      #6;
      cs_n_o = 1'b1;
      // A released line must not keep looking like the last bit.
      mosi_o = ~mosi_o;
   endtask
endmodule // spi_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the serial status responder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import status_resp_pkg::*;
   logic           clk_i;
   logic           rst_i;
   pending_flags_t flags_i;
   pending_flags_t fv;
   logic           sclk;
   logic           cs_n;
   logic           mosi;
   logic           miso;
   logic           miso_oe;
   logic [15:0]    status_w;
   logic           pend_any;
   command_t       cmd_out;
   cmd_kind_t      kind;
   logic [15:0]    rx;
   logic [15:0]    exp;
   logic [1:0]     ct;
   int             failures;
   int             checked;

   spi_status_response dut (
      .clk_i(clk_i), .rst_i(rst_i), .flags_i(flags_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .status_word_o(status_w),
      .pending_any_o(pend_any), .command_o(cmd_out), .command_kind_o(kind));
   spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask

   function automatic logic [15:0] word_of(input logic [12:0] f);
      return {f[12:10], |f[7:6], |f[5:4], |f[3:2], f[9], f[8] | (|f[1:0]), f[7:0]};
   endfunction

   task automatic clks(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // Each frame end must raise the command strobe for exactly one cycle.
   task automatic wait_cmd();
      logic [15:0] seen;
      seen = 16'h0000;
      repeat (5) begin
         @(negedge clk_i);
         seen = seen + 16'(cmd_out.valid);
      end
      check(seen, 16'h0001);
   endtask

   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #300000;
      failures++;
      wrap_up();
   end

   initial begin
      failures = 0;
      checked = 0;
      rst_i = 1'b1;
      flags_i = '0;
      clks(5);
      rst_i <= 1'b0;
      check(status_w, 16'h0000);
      check(16'(pend_any), 16'h0000);
      clks(4);
      // Each source alone, with the command type cycling through all four codes.
      for (int i = 0; i < 13; i++) begin
         fv = 13'h1 << i;
         flags_i <= fv;
         ct = i[1:0];
         exp = word_of(fv);
         clks(4);
         check(status_w, exp);
         check(16'(pend_any), 16'(|exp[15:13]));
         host.frame({ct, 14'h0a5c}, 16, rx);
         check(rx, ct == 2'h1 ? exp : {exp[15:8], 8'h00});
         wait_cmd();
         check(cmd_out.word, {ct, 14'h0a5c});
         check(16'(cmd_out.is_write), 16'(ct == 2'h1));
         check(16'(kind), 16'(ct == 2'h1 ? CMD_KIND_WRITE :
                              ct == 2'h2 ? CMD_KIND_UNKNOWN : CMD_KIND_READ));
         check(16'(cmd_out.length_error), 16'h0000);
      end
      host.frame(16'h4321, 11, rx);
      wait_cmd();
      check(16'(cmd_out.length_error), 16'h0001);
      // Every flag set, then all cleared while a write frame is in flight.
      fv = '1;
      flags_i <= fv;
      clks(4);
      check(status_w, word_of(fv));
      check(16'(pend_any), 16'h0001);
      fork
         host.frame(16'h4000, 16, rx);
         begin
            clks(4);
            flags_i <= '0;
         end
      join
      check(rx, word_of(fv));
      clks(5);
      host.frame(16'h0000, 16, rx);
      check(rx, 16'h0000);
      clks(5);
      check(16'(pend_any), 16'h0000);
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
